// ==== hw/fuse_and_parallel_prog_ctrl.v ====
// fuse store, reset output forcing and parallel programming front end
`timescale 1ns/1ps
`default_nettype none
`include "fuse_prog_consts.vh"
module fuse_and_parallel_prog_ctrl #(
  parameter [7:0] SIG_BYTE0 = 8'hA5,
  parameter [7:0] SIG_BYTE1 = 8'h5A,
  parameter [7:0] SIG_BYTE2 = 8'h3C,
  parameter [7:0] CAL_BYTE = 8'h80
) (
  input wire clk_in,
  input wire rst_in,
  input wire por_in,
  input wire prog_mode_in,
  input wire crystal_strobe_in,
  input wire action_select_bit0_in,
  input wire action_select_bit1_in,
  input wire byte_select_one_in,
  input wire byte_select_two_in,
  input wire page_load_strobe_in,
  input wire write_strobe_n_in,
  input wire output_enable_n_in,
  input wire [7:0] data_in,
  output reg [7:0] data_out,
  output wire data_oe_out,
  output wire ready_busy_out,
  input wire serial_prog_mode_in,
  input wire serial_fuse_write_in,
  input wire [1:0] serial_fuse_select_in,
  input wire [7:0] serial_fuse_data_in,
  output reg mem_req_out,
  output reg [1:0] mem_op_out,
  output reg mem_keep_eeprom_out,
  input wire mem_done_in,
  output wire [6:0] flash_page_index_out,
  output wire [4:0] flash_word_in_page_index_out,
  output wire [6:0] eeprom_page_index_out,
  output wire [1:0] eeprom_byte_in_page_out,
  input wire [15:0] flash_rdata_in,
  input wire [7:0] eeprom_rdata_in,
  output reg page_buf_write_out,
  output reg [15:0] page_buf_data_out,
  output reg [7:0] low_fuse_out,
  output reg [7:0] high_fuse_out,
  output reg [7:0] ext_fuse_out,
  output wire eeprom_preserve_fuse_out,
  output reg [7:0] osc_calibration_reg_out,
  input wire stage0_output_config_write_in,
  input wire stage1_output_config_write_in,
  input wire stage2_output_config_write_in,
  input wire [1:0] stage0_port_in,
  input wire [1:0] stage1_port_in,
  input wire [3:0] stage2_port_in,
  output wire [1:0] stage0_output_out,
  output wire [1:0] stage1_output_out,
  output wire [3:0] stage2_output_out
);
  localparam ST_IDLE = 2'h0;
  localparam ST_MEM = 2'h1;
  localparam ST_FUSE = 2'h2;
  localparam integer FUSE_WR_INT = `FUSE_WR_CYCLES;
  localparam [7:0] FUSE_WR_COUNT = FUSE_WR_INT[7:0];

  wire [16:0] pins_raw;
  wire [16:0] pins;
  wire prog_pin;
  wire strobe_pin;
  wire [1:0] action;
  wire bs1;
  wire bs2;
  wire page_load_strobe_pin;
  wire wr_n;
  wire oe_n;
  wire [7:0] bus_data;

  // stored cells, kept across ordinary reset
  reg [7:0] low_fuse_cell;
  reg [7:0] high_fuse_cell;
  reg [7:0] ext_fuse_cell;
  reg [7:0] lock_cell;
  reg por_seen;

  reg prog_prev;
  reg strobe_prev;
  reg page_load_strobe_prev;
  reg wr_prev;
  reg prog_active;
  reg [7:0] command;
  reg [7:0] addr_low;
  reg [7:0] addr_high;
  reg [7:0] data_low;
  reg [7:0] data_high;
  reg [1:0] state;
  reg [7:0] fuse_count;
  reg [7:0] next_data_out;

  wire entering;
  wire strobe_rise;
  wire page_load_strobe_rise;
  wire wr_fall;
  wire fuses_locked;
  wire [`FLASH_ADDR_W-1:0] flash_addr;
  wire [`EEPROM_ADDR_W-1:0] eeprom_addr;

  assign pins_raw = {prog_mode_in, crystal_strobe_in, action_select_bit1_in,
                     action_select_bit0_in, byte_select_one_in, byte_select_two_in,
                     page_load_strobe_in, write_strobe_n_in, output_enable_n_in, data_in};

  pin_sync #(
    .W(17),
    .INIT(17'h00300)
  ) u_pin_sync (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .async_in(pins_raw),
    .sync_out(pins)
  );

  assign prog_pin = pins[16];
  assign strobe_pin = pins[15];
  assign action = pins[14:13];
  assign bs1 = pins[12];
  assign bs2 = pins[11];
  assign page_load_strobe_pin = pins[10];
  assign wr_n = pins[9];
  assign oe_n = pins[8];
  assign bus_data = pins[7:0];

  always @(posedge clk_in) begin
    if (rst_in) begin
      prog_prev <= 1'b0;
      strobe_prev <= 1'b0;
      page_load_strobe_prev <= 1'b0;
      wr_prev <= 1'b1;
    end else begin
      prog_prev <= prog_pin;
      strobe_prev <= strobe_pin;
      page_load_strobe_prev <= page_load_strobe_pin;
      wr_prev <= wr_n;
    end
  end

  // entry pattern must be all zero
  assign entering = prog_pin && !prog_prev && !page_load_strobe_pin && (action == 2'h0) && !bs1;
  assign strobe_rise = prog_active && strobe_pin && !strobe_prev;
  assign page_load_strobe_rise = prog_active && page_load_strobe_pin && !page_load_strobe_prev;
  assign wr_fall = prog_active && !wr_n && wr_prev;
  // lock bit one programmed locks the fuses
  assign fuses_locked = !lock_cell[`LOCK_BIT_ONE];

  // flash word address split into page and word
  assign flash_addr = {addr_high[3:0], addr_low};
  assign flash_page_index_out = flash_addr[`FLASH_ADDR_W-1:`FLASH_WORD_W];
  assign flash_word_in_page_index_out = flash_addr[`FLASH_WORD_W-1:0];
  // eeprom byte address split into page and byte
  assign eeprom_addr = {addr_high[0], addr_low};
  assign eeprom_page_index_out = eeprom_addr[`EEPROM_ADDR_W-1:`EEPROM_BYTE_W];
  assign eeprom_byte_in_page_out = eeprom_addr[`EEPROM_BYTE_W-1:0];

  always @(posedge clk_in) begin
    if (rst_in) begin
      prog_active <= 1'b0;
      command <= `CMD_NOP;
      addr_low <= 8'h00;
      addr_high <= 8'h00;
      data_low <= 8'hFF;
      data_high <= 8'hFF;
    end else begin
      if (!prog_pin) begin
        prog_active <= 1'b0;
      end else if (entering) begin
        prog_active <= 1'b1;
      end
      if (strobe_rise && state == ST_IDLE) begin
        case (action)
          `ACT_LOAD_ADDR: begin
            if (bs1) begin
              addr_high <= bus_data;
            end else begin
              addr_low <= bus_data;
            end
          end
          `ACT_LOAD_DATA: begin
            if (bs1) begin
              data_high <= bus_data;
            end else begin
              data_low <= bus_data;
            end
          end
          `ACT_LOAD_CMD: begin
            command <= bus_data;
          end
          default: begin
          end
        endcase
      end
    end
  end

  // page buffer load on the page-load strobe
  always @(posedge clk_in) begin
    if (rst_in) begin
      page_buf_write_out <= 1'b0;
      page_buf_data_out <= 16'h0000;
    end else begin
      page_buf_write_out <= page_load_strobe_rise &&
        (command == `CMD_WRITE_FLASH || command == `CMD_WRITE_EEPROM);
      if (page_load_strobe_rise) begin
        page_buf_data_out <= {data_high, data_low};
      end
    end
  end

  // operation sequencer
  always @(posedge clk_in) begin
    if (rst_in) begin
      state <= ST_IDLE;
      fuse_count <= 8'h00;
      mem_req_out <= 1'b0;
      mem_op_out <= `MEM_OP_ERASE;
      mem_keep_eeprom_out <= 1'b0;
    end else begin
      mem_req_out <= 1'b0;
      case (state)
        ST_IDLE: begin
          // write pulse runs the loaded command
          if (wr_fall) begin
            case (command)
              `CMD_CHIP_ERASE: begin
                mem_req_out <= 1'b1;
                mem_op_out <= `MEM_OP_ERASE;
                mem_keep_eeprom_out <= !high_fuse_cell[`HF_EEPROM_PRESERVE];
                state <= ST_MEM;
              end
              `CMD_WRITE_FLASH: begin
                mem_req_out <= 1'b1;
                mem_op_out <= `MEM_OP_FLASH_PAGE;
                state <= ST_MEM;
              end
              `CMD_WRITE_EEPROM: begin
                mem_req_out <= 1'b1;
                mem_op_out <= `MEM_OP_EEPROM_PAGE;
                state <= ST_MEM;
              end
              `CMD_WRITE_FUSE, `CMD_WRITE_LOCK: begin
                fuse_count <= FUSE_WR_COUNT;
                state <= ST_FUSE;
              end
              default: begin
              end
            endcase
          end
        end
        ST_MEM: begin
          if (mem_done_in) begin
            state <= ST_IDLE;
          end
        end
        ST_FUSE: begin
          if (fuse_count <= 8'h01) begin
            state <= ST_IDLE;
          end
          fuse_count <= fuse_count - 8'h01;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  assign ready_busy_out = (state == ST_IDLE);

  // fuse and lock cells
  always @(posedge clk_in) begin
    if (por_in) begin
      low_fuse_cell <= `LOW_FUSE_DEFAULT;
      high_fuse_cell <= `HIGH_FUSE_DEFAULT;
      ext_fuse_cell <= `EXT_FUSE_DEFAULT;
      lock_cell <= `LOCK_BYTE_DEFAULT;
    end else if (!rst_in) begin
      if (wr_fall && state == ST_IDLE) begin
        // erase clears locks only, fuses untouched
        if (command == `CMD_CHIP_ERASE) begin
          lock_cell <= `LOCK_BYTE_DEFAULT;
        end
        // locks can only be programmed further
        if (command == `CMD_WRITE_LOCK) begin
          lock_cell <= lock_cell & data_low;
        end
        // parallel fuse write refused when locked
        if (command == `CMD_WRITE_FUSE && !fuses_locked) begin
          // byte selects pick low, high or extended byte
          if (bs2) begin
            ext_fuse_cell <= data_low;
          end else if (bs1) begin
            high_fuse_cell <= data_low;
          end else begin
            low_fuse_cell <= data_low;
          end
        end
      end else if (serial_prog_mode_in && serial_fuse_write_in && !fuses_locked) begin
        case (serial_fuse_select_in)
          2'h0: begin
            low_fuse_cell <= serial_fuse_data_in;
          end
          2'h1: begin
            // serial writes keep the serial enable bit
            high_fuse_cell <= {serial_fuse_data_in[7:6],
                               high_fuse_cell[`HF_SERIAL_PROG_ENABLE],
                               serial_fuse_data_in[4:0]};
          end
          2'h2: begin
            ext_fuse_cell <= serial_fuse_data_in;
          end
          default: begin
          end
        endcase
      end
    end
  end

  // latch fuses at power-up and programming entry
  always @(posedge clk_in) begin
    if (por_in) begin
      por_seen <= 1'b0;
      low_fuse_out <= `LOW_FUSE_DEFAULT;
      high_fuse_out <= `HIGH_FUSE_DEFAULT;
      ext_fuse_out <= `EXT_FUSE_DEFAULT;
    end else begin
      por_seen <= 1'b1;
      if (!por_seen || (entering && !rst_in)) begin
        low_fuse_out <= low_fuse_cell;
        high_fuse_out <= high_fuse_cell;
        ext_fuse_out <= ext_fuse_cell;
      end
    end
  end

  // preserve fuse taken straight from the cell
  assign eeprom_preserve_fuse_out = high_fuse_cell[`HF_EEPROM_PRESERVE];

  always @(posedge clk_in) begin
    if (rst_in || por_in) begin
      osc_calibration_reg_out <= CAL_BYTE;
    end
  end

  // read data mux
  always @* begin
    next_data_out = 8'hFF;
    case (command)
      `CMD_READ_SIG: begin
        if (bs1) begin
          next_data_out = CAL_BYTE;
        end else if (addr_low[1:0] == `SIG_ADDR_0) begin
          next_data_out = SIG_BYTE0;
        end else if (addr_low[1:0] == `SIG_ADDR_1) begin
          next_data_out = SIG_BYTE1;
        end else if (addr_low[1:0] == `SIG_ADDR_2) begin
          next_data_out = SIG_BYTE2;
        end
      end
      // cells read back raw, 0 programmed
      `CMD_READ_FUSE_LOCK: begin
        case ({bs2, bs1})
          2'h0: next_data_out = low_fuse_cell;
          2'h1: next_data_out = lock_cell;
          2'h2: next_data_out = ext_fuse_cell;
          default: next_data_out = high_fuse_cell;
        endcase
      end
      `CMD_READ_FLASH: begin
        next_data_out = bs1 ? flash_rdata_in[15:8] : flash_rdata_in[7:0];
      end
      `CMD_READ_EEPROM: begin
        next_data_out = eeprom_rdata_in;
      end
      default: begin
        next_data_out = 8'hFF;
      end
    endcase
  end

  always @(posedge clk_in) begin
    if (rst_in) begin
      data_out <= 8'hFF;
    end else begin
      data_out <= next_data_out;
    end
  end

  // drive the bus only under output enable
  assign data_oe_out = prog_active && !oe_n && !strobe_pin;

  // level and force bits from the extended byte
  stage_reset_force #(
    .N(2)
  ) u_stage0 (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .force_fuse_in(ext_fuse_out[`EF_STAGE0_FORCE]),
    .level_fuse_in(ext_fuse_out[`EF_RESET_LEVEL]),
    .config_write_in(stage0_output_config_write_in),
    .port_in(stage0_port_in),
    .pin_out(stage0_output_out)
  );

  stage_reset_force #(
    .N(2)
  ) u_stage1 (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .force_fuse_in(ext_fuse_out[`EF_STAGE1_FORCE]),
    .level_fuse_in(ext_fuse_out[`EF_RESET_LEVEL]),
    .config_write_in(stage1_output_config_write_in),
    .port_in(stage1_port_in),
    .pin_out(stage1_output_out)
  );

  stage_reset_force #(
    .N(4)
  ) u_stage2 (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .force_fuse_in(ext_fuse_out[`EF_STAGE2_FORCE]),
    .level_fuse_in(ext_fuse_out[`EF_RESET_LEVEL]),
    .config_write_in(stage2_output_config_write_in),
    .port_in(stage2_port_in),
    .pin_out(stage2_output_out)
  );

  // field layout lives in the latched bytes
endmodule
`default_nettype wire

// ==== hw/fuse_prog_consts.vh ====
// constants for the fuse store and parallel programming front end
`ifndef FUSE_PROG_CONSTS_VH
`define FUSE_PROG_CONSTS_VH

// fuse byte defaults, 0 = programmed
`define LOW_FUSE_DEFAULT 8'h62
`define HIGH_FUSE_DEFAULT 8'hDF
`define EXT_FUSE_DEFAULT 8'hF9
`define LOCK_BYTE_DEFAULT 8'hFF

// high fuse byte fields
`define HF_EXT_RESET_DISABLE 7
`define HF_DEBUG_LINK_ENABLE 6
`define HF_SERIAL_PROG_ENABLE 5
`define HF_WATCHDOG_ALWAYS_ON 4
`define HF_EEPROM_PRESERVE 3
`define HF_BROWNOUT_MSB 2
`define HF_BROWNOUT_LSB 0

// low fuse byte fields
`define LF_CLOCK_DIV8 7
`define LF_CLOCK_OUTPUT 6
`define LF_STARTUP_MSB 5
`define LF_STARTUP_LSB 4
`define LF_CLOCK_SOURCE_MSB 3
`define LF_CLOCK_SOURCE_LSB 0

// extended fuse byte fields
`define EF_STAGE2_FORCE 7
`define EF_STAGE1_FORCE 6
`define EF_STAGE0_FORCE 5
`define EF_RESET_LEVEL 4
`define EF_BOOT_SIZE_MSB 2
`define EF_BOOT_SIZE_LSB 1
`define EF_RESET_VECTOR 0

// lock byte field
`define LOCK_BIT_ONE 0

// strobe action coding {bit1,bit0}
`define ACT_LOAD_ADDR 2'h0
`define ACT_LOAD_DATA 2'h1
`define ACT_LOAD_CMD 2'h2
`define ACT_IDLE 2'h3

// command bytes
`define CMD_NOP 8'h00
`define CMD_CHIP_ERASE 8'h80
`define CMD_WRITE_FUSE 8'h40
`define CMD_WRITE_LOCK 8'h20
`define CMD_WRITE_FLASH 8'h10
`define CMD_WRITE_EEPROM 8'h11
`define CMD_READ_SIG 8'h08
`define CMD_READ_FUSE_LOCK 8'h04
`define CMD_READ_FLASH 8'h02
`define CMD_READ_EEPROM 8'h03

// memory operation codes toward the array controller
`define MEM_OP_ERASE 2'h0
`define MEM_OP_FLASH_PAGE 2'h1
`define MEM_OP_EEPROM_PAGE 2'h2

// flash and eeprom geometry
`define FLASH_ADDR_W 12
`define FLASH_WORD_W 5
`define EEPROM_ADDR_W 9
`define EEPROM_BYTE_W 2

// signature space addresses
`define SIG_ADDR_0 2'h0
`define SIG_ADDR_1 2'h1
`define SIG_ADDR_2 2'h2

// fuse and lock cell write time
`define CLK_PERIOD_NS 25
`define FUSE_WR_TIME_NS 400
`define FUSE_WR_CYCLES ((`FUSE_WR_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ==== hw/pin_sync.v ====
// two-flop synchroniser for a group of pins
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter W = 1,
  parameter [W-1:0] INIT = {W{1'b0}}
) (
  input wire clk_in,
  input wire rst_in,
  input wire [W-1:0] async_in,
  output wire [W-1:0] sync_out
);
  reg [W-1:0] stage1;
  reg [W-1:0] stage2;

  always @(posedge clk_in) begin
    if (rst_in) begin
      stage1 <= INIT;
      stage2 <= INIT;
    end else begin
      stage1 <= async_in;
      stage2 <= stage1;
    end
  end

  assign sync_out = stage2;
endmodule
`default_nettype wire

// ==== hw/stage_reset_force.v ====
// reset forcing of one power stage's outputs
`timescale 1ns/1ps
`default_nettype none
module stage_reset_force #(
  parameter N = 2
) (
  input wire clk_in,
  input wire rst_in,
  input wire force_fuse_in,
  input wire level_fuse_in,
  input wire config_write_in,
  input wire [N-1:0] port_in,
  output wire [N-1:0] pin_out
);
  reg hold;

  always @(posedge clk_in) begin
    if (rst_in) begin
      hold <= 1'b1;
    end else if (config_write_in) begin
      hold <= 1'b0;
    end
  end

  // forced level while in reset or until the config register is written
  assign pin_out = (hold && !force_fuse_in) ? {N{level_fuse_in}} : port_in;
endmodule
`default_nettype wire

// ==== verif/fuse_prog_chk.sv ====
// port assertions for the fuse and programming block
`timescale 1ns/1ps
`default_nettype none
module fuse_prog_chk #(
  parameter [7:0] CAL = 8'h80
) (
  input wire clk_in,
  input wire rst_in,
  input wire por_in,
  input wire prog_mode_in,
  input wire output_enable_n_in,
  input wire data_oe_out,
  input wire ready_busy_out,
  input wire mem_req_out,
  input wire mem_done_in,
  input wire [7:0] high_fuse_out,
  input wire [7:0] ext_fuse_out,
  input wire [7:0] osc_calibration_reg_out,
  input wire [1:0] stage0_port_in,
  input wire [1:0] stage1_port_in,
  input wire [3:0] stage2_port_in,
  input wire [1:0] stage0_output_out,
  input wire [1:0] stage1_output_out,
  input wire [3:0] stage2_output_out
);
  default clocking @(posedge clk_in); endclocking
  AST_OE_OFF: assert property (disable iff (rst_in)
    output_enable_n_in [*3] |-> !data_oe_out) else $error("bus driven without enable");
  AST_REQ_BUSY: assert property (disable iff (rst_in)
    mem_req_out |-> !ready_busy_out ##1 !mem_req_out) else $error("request not busy");
  AST_DONE_READY: assert property (disable iff (rst_in)
    mem_done_in && !ready_busy_out |-> ##[1:2] ready_busy_out) else $error("ready late");
  AST_RST_READY: assert property (disable iff (por_in)
    rst_in |=> ready_busy_out && !data_oe_out) else $error("busy in reset");
  AST_CAL: assert property (disable iff (por_in)
    rst_in |=> osc_calibration_reg_out == CAL) else $error("calibration not loaded");
  AST_LATCH: assert property (disable iff (rst_in || por_in)
    prog_mode_in [*6] |-> $stable(high_fuse_out) && $stable(ext_fuse_out))
    else $error("latched fuse moved in programming");
  AST_FORCE0: assert property (disable iff (por_in)
    rst_in && $past(rst_in) && !ext_fuse_out[5] |-> stage0_output_out == {2{ext_fuse_out[4]}})
    else $error("stage0 not forced");
  AST_FORCE1: assert property (disable iff (por_in)
    rst_in && $past(rst_in) && !ext_fuse_out[6] |-> stage1_output_out == {2{ext_fuse_out[4]}})
    else $error("stage1 not forced");
  AST_FORCE2: assert property (disable iff (por_in)
    rst_in && $past(rst_in) && !ext_fuse_out[7] |-> stage2_output_out == {4{ext_fuse_out[4]}})
    else $error("stage2 not forced");
  AST_PORT: assert property (disable iff (por_in)
    &ext_fuse_out[7:5] |-> stage0_output_out == stage0_port_in &&
    stage1_output_out == stage1_port_in && stage2_output_out == stage2_port_in)
    else $error("unforced stage not port");
endmodule
bind fuse_and_parallel_prog_ctrl fuse_prog_chk #(.CAL(CAL_BYTE)) fuse_prog_chk_i (.*);
`default_nettype wire

// ==== verif/array_model.sv ====
// memory array stand-in answering page and erase requests
`timescale 1ns/1ps
`default_nettype none
module array_model (
  input wire logic clk_in,
  input wire logic req_in,
  input wire logic [1:0] op_in,
  input wire logic keep_in,
  input wire logic [11:0] faddr_in,
  input wire logic [8:0] eaddr_in,
  output logic done_out,
  output logic [15:0] frd_out,
  output logic [7:0] erd_out
);
  logic [2:0] cnt = 3'h0;
  logic [1:0] last_op = 2'h3;
  logic last_keep = 1'b0;
  // read data follows page and index
  assign frd_out = {4'hB, faddr_in};
  assign erd_out = ~eaddr_in[7:0];
  assign done_out = (cnt == 3'h1);
  always @(posedge clk_in) begin
    if (req_in) begin
      cnt <= 3'h6;
      last_op <= op_in;
      last_keep <= keep_in;
    end else if (cnt != 3'h0) begin
      cnt <= cnt - 3'h1;
    end
  end
endmodule
`default_nettype wire

// ==== verif/fuse_and_parallel_prog_ctrl_tb_top.sv ====
// bench for the fuse store and parallel programming block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_fail++; $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module fuse_and_parallel_prog_ctrl_tb_top;
  logic clk_in = 0, rst_in = 1, por_in = 1, prog_mode_in = 0, crystal_strobe_in = 0;
  logic action_select_bit0_in = 0, action_select_bit1_in = 0, byte_select_one_in = 0;
  logic byte_select_two_in = 0, page_load_strobe_in = 0, write_strobe_n_in = 1;
  logic output_enable_n_in = 1, serial_prog_mode_in = 0, serial_fuse_write_in = 0;
  logic stage0_output_config_write_in = 0, stage1_output_config_write_in = 0;
  logic stage2_output_config_write_in = 0, rb;
  logic [1:0] serial_fuse_select_in = 0, stage0_port_in = 3, stage1_port_in = 3;
  logic [3:0] stage2_port_in = 4'hF;
  logic [7:0] serial_fuse_data_in = 0, din = 0;
  int n_fail = 0, checks = 0, n_pbw = 0;
  wire [7:0] data_in, data_out, low_fuse_out, high_fuse_out, ext_fuse_out, eeprom_rdata_in;
  wire [7:0] osc_calibration_reg_out;
  wire data_oe_out, ready_busy_out, mem_req_out, mem_keep_eeprom_out, mem_done_in;
  wire page_buf_write_out, eeprom_preserve_fuse_out;
  wire [1:0] mem_op_out, stage0_output_out, stage1_output_out, eeprom_byte_in_page_out;
  wire [3:0] stage2_output_out;
  wire [6:0] flash_page_index_out, eeprom_page_index_out;
  wire [4:0] flash_word_in_page_index_out;
  wire [15:0] flash_rdata_in, page_buf_data_out;
  assign data_in = data_oe_out ? data_out : din;
  // arbitrary identity values
  fuse_and_parallel_prog_ctrl #(.SIG_BYTE0(8'h4B), .SIG_BYTE1(8'h2C), .SIG_BYTE2(8'h77),
    .CAL_BYTE(8'h9D)) fuse_and_parallel_prog_ctrl_i (.*);
  array_model array_model_i (.clk_in(clk_in), .req_in(mem_req_out), .op_in(mem_op_out),
    .keep_in(mem_keep_eeprom_out), .done_out(mem_done_in),
    .faddr_in({flash_page_index_out, flash_word_in_page_index_out}),
    .eaddr_in({eeprom_page_index_out, eeprom_byte_in_page_out}),
    .frd_out(flash_rdata_in), .erd_out(eeprom_rdata_in));
  always #12.5 clk_in = ~clk_in;
  // count page buffer write pulses
  always @(posedge clk_in) if (page_buf_write_out === 1'b1) n_pbw <= n_pbw + 1;
  task cyc(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  task xs(input [1:0] a, input b1, input [7:0] d);
    cyc(1);
    {action_select_bit1_in, action_select_bit0_in} <= a;
    byte_select_one_in <= b1;
    din <= d;
    cyc(3);
    crystal_strobe_in <= 1;
    cyc(4);
    crystal_strobe_in <= 0;
    cyc(4);
  endtask
  task wr(input b1, input b2);
    cyc(1);
    byte_select_one_in <= b1;
    byte_select_two_in <= b2;
    cyc(2);
    write_strobe_n_in <= 0;
    cyc(4);
    rb = ready_busy_out;
    write_strobe_n_in <= 1;
    for (int i = 0; i < 60 && ready_busy_out !== 1'b1; i++) cyc(1);
    `CHK(ready_busy_out, 1'b1)
    cyc(2);
  endtask
  task rd(input b1, input b2, input [7:0] e);
    cyc(1);
    byte_select_one_in <= b1;
    byte_select_two_in <= b2;
    output_enable_n_in <= 0;
    cyc(5);
    `CHK(data_oe_out, 1'b1)
    `CHK(data_out, e)
    output_enable_n_in <= 1;
    cyc(3);
  endtask
  task enter;
    cyc(1);
    prog_mode_in <= 0;
    {page_load_strobe_in, action_select_bit1_in, action_select_bit0_in} <= 3'h0;
    byte_select_one_in <= 0;
    cyc(5);
    prog_mode_in <= 1;
    cyc(6);
  endtask
  task t_defaults;
    enter();
    `CHK(ready_busy_out, 1'b1)
    `CHK(low_fuse_out, 8'h62)
    `CHK(high_fuse_out, 8'hDF)
    `CHK(ext_fuse_out, 8'hF9)
    `CHK(osc_calibration_reg_out, 8'h9D)
    $display("test defaults done");
  endtask
  task t_sig;
    logic [7:0] sig [3];
    sig = '{8'h4B, 8'h2C, 8'h77};
    xs(2'h2, 0, 8'h08);
    for (int a = 0; a < 3; a++) begin
      xs(2'h0, 0, a[7:0]);
      rd(0, 0, sig[a]);
    end
    rd(1, 0, 8'h9D);
    $display("test signature done");
  endtask
  task t_fuse;
    xs(2'h2, 0, 8'h40);
    xs(2'h1, 0, 8'h0F);
    wr(0, 0);
    `CHK(rb, 1'b0)
    xs(2'h1, 0, 8'hD7);
    wr(1, 0);
    `CHK(eeprom_preserve_fuse_out, 1'b0)
    `CHK(high_fuse_out, 8'hDF)
    xs(2'h1, 0, 8'h09);
    wr(0, 1);
    cyc(1);
    serial_prog_mode_in <= 1;
    serial_fuse_select_in <= 2'h1;
    serial_fuse_data_in <= 8'hF5;
    serial_fuse_write_in <= 1;
    cyc(1);
    serial_fuse_write_in <= 0;
    serial_prog_mode_in <= 0;
    xs(2'h2, 0, 8'h04);
    rd(0, 0, 8'h0F);
    rd(0, 1, 8'h09);
    rd(1, 1, 8'hD5);
    $display("test fuse write done");
  endtask
  task t_force;
    enter();
    `CHK(ext_fuse_out, 8'h09)
    stage0_port_in <= 2'h2;
    stage1_port_in <= 2'h1;
    stage2_port_in <= 4'hA;
    rst_in <= 1;
    cyc(4);
    `CHK({stage2_output_out, stage1_output_out, stage0_output_out}, 8'h00)
    rst_in <= 0;
    cyc(3);
    `CHK(stage0_output_out, 2'h0)
    stage0_output_config_write_in <= 1;
    cyc(1);
    stage0_output_config_write_in <= 0;
    cyc(2);
    `CHK(stage0_output_out, 2'h2)
    `CHK(stage1_output_out, 2'h0)
    stage1_output_config_write_in <= 1;
    stage2_output_config_write_in <= 1;
    cyc(1);
    stage1_output_config_write_in <= 0;
    stage2_output_config_write_in <= 0;
    cyc(2);
    `CHK({stage2_output_out, stage1_output_out}, 6'h29)
    enter();
    $display("test force done");
  endtask
  task t_mem;
    xs(2'h2, 0, 8'h10);
    xs(2'h0, 0, 8'hA3);
    xs(2'h0, 1, 8'h05);
    xs(2'h1, 0, 8'h34);
    xs(2'h1, 1, 8'h12);
    page_load_strobe_in <= 1;
    cyc(4);
    page_load_strobe_in <= 0;
    cyc(4);
    `CHK(page_buf_data_out, 16'h1234)
    `CHK(n_pbw, 1)
    `CHK({flash_page_index_out, flash_word_in_page_index_out}, 12'h5A3)
    `CHK({eeprom_page_index_out, eeprom_byte_in_page_out}, 9'h1A3)
    wr(1, 0);
    `CHK(array_model_i.last_op, 2'h1)
    xs(2'h2, 0, 8'h11);
    wr(0, 0);
    `CHK(array_model_i.last_op, 2'h2)
    xs(2'h2, 0, 8'h02);
    xs(2'h3, 0, 8'h00);
    rd(0, 0, 8'hA3);
    rd(1, 0, 8'hB5);
    xs(2'h2, 0, 8'h03);
    rd(0, 0, 8'h5C);
    $display("test memory done");
  endtask
  task t_lock_erase;
    xs(2'h2, 0, 8'h20);
    xs(2'h1, 0, 8'hFE);
    wr(0, 0);
    xs(2'h2, 0, 8'h40);
    xs(2'h1, 0, 8'hFF);
    wr(0, 0);
    xs(2'h2, 0, 8'h04);
    rd(0, 0, 8'h0F);
    rd(1, 0, 8'hFE);
    xs(2'h2, 0, 8'h80);
    wr(0, 0);
    `CHK(array_model_i.last_op, 2'h0)
    `CHK(array_model_i.last_keep, 1'b1)
    xs(2'h2, 0, 8'h04);
    rd(1, 0, 8'hFF);
    rd(1, 1, 8'hD5);
    $display("test lock and erase done");
  endtask
  task conclude;
    $display("checks %0d failures %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    #750000;
    n_fail++;
    conclude();
  end
  initial begin
    cyc(12);
    rst_in <= 0;
    por_in <= 0;
    cyc(4);
    t_defaults();
    t_sig();
    t_fuse();
    t_force();
    t_mem();
    t_lock_erase();
    conclude();
  end
endmodule
`default_nettype wire
